// file: design/ssr_pkg.sv
package ssr_pkg;
    localparam int W = 16;
    // request source select codes
    localparam logic [2:0] SRC_HOST   = 3'h0;
    localparam logic [2:0] SRC_PANEL  = 3'h1;
    localparam logic [2:0] SRC_CONT_A = 3'h2;
    localparam logic [2:0] SRC_CONT_B = 3'h3;
    localparam logic [2:0] SRC_CONT_C = 3'h4;
    localparam logic [2:0] SRC_CONT_D = 3'h5;
    // analog input select codes
    localparam logic [1:0] AIN_DEFAULT  = 2'h0;
    localparam logic [1:0] AIN_ISOLATED = 2'h1;
    localparam logic [1:0] AIN_FEEDBACK = 2'h2;
    // limit selector modes
    localparam logic [1:0] LIM_OFF = 2'h0;
    localparam logic [1:0] LIM_MIN = 2'h1;
    localparam logic [1:0] LIM_MAX = 2'h2;
    // gradient code meaning ramp bypassed
    localparam logic [15:0] GRAD_OFF = 16'h0000;
    localparam logic [15:0] TARGET_RESET = 16'h0000;
    // control cycle
    localparam int CYCLE_NS = 100000;
    localparam int CLK_NS = 10;
    localparam logic [15:0] CYCLE_CLKS = 16'(CYCLE_NS / CLK_NS);
    typedef enum logic [3:0] {
        SSR_IDLE   = 4'b0001,
        SSR_SELECT = 4'b0010,
        SSR_COMB   = 4'b0100,
        SSR_RAMP   = 4'b1000
    } ssr_state_t;
endpackage

// file: design/ssr_req_if.sv
`timescale 1ns/10ps
interface ssr_req_if;
    logic host;
    logic panel;
    logic contact_input_a;
    logic contact_input_b;
    logic contact_input_c;
    logic contact_input_d;
    logic [2:0] src_sel;
    logic wins;
    modport owner (output host, panel, contact_input_a, contact_input_b,
                   contact_input_c, contact_input_d, src_sel, input wins);
    modport arbiter (input host, panel, contact_input_a, contact_input_b,
                     contact_input_c, contact_input_d, src_sel, output wins);
endinterface

// file: design/ssr_prio.sv
`timescale 1ns/10ps
module ssr_prio
    import ssr_pkg::*;
(
    ssr_req_if.arbiter req
);
    // a request active at any source that is enabled wins over others
    function automatic logic pick(input logic [2:0] s, input logic h, input logic p,
                                  input logic a, input logic b, input logic c,
                                  input logic d);
        logic r;
        r = 1'b0;
        if (s == SRC_HOST) begin
            r = h;
        end else if (s == SRC_PANEL) begin
            r = p;
        end else if (s == SRC_CONT_A) begin
            r = a;
        end else if (s == SRC_CONT_B) begin
            r = b;
        end else if (s == SRC_CONT_C) begin
            r = c;
        end else if (s == SRC_CONT_D) begin
            r = d;
        end
        return r;
    endfunction
    // host and panel always count; the configured contact adds to them
    assign req.wins = req.host | req.panel |
        pick(req.src_sel, 1'b0, 1'b0, req.contact_input_a, req.contact_input_b,
             req.contact_input_c, req.contact_input_d);
endmodule

// file: design/ssr_top.sv
`timescale 1ns/10ps
// Function
// - contact 1 remote, 0 local target
// - local/remote request from host, panel, contacts
// - remote from input five, four or six
// - local request from any source wins
// - offset added or multiplied per config
// - offset on at 1, off at 0
// - offset enable and value sources configurable
// - offset-on request from any source wins
// - target change ramps with rise/fall gradient
// - gradient also limits profile target
// - second target uses its own gradient
// - disabled gradient code means immediate step
// - switch-over or power-on ramps from process
// - process-value start ignores target limits
// - target tracking copies prior target locally
// - return from local ramps with gradients
// - process tracking stores process value
// - configuration selects tracking type
// - bumpless contact only arms switch type
// - bumpless request from any source wins
// - active target clamped against limit input
// - limit works with any target mode
// - second target overrides all sources
module ssr_top
    import ssr_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_b,
    input  wire logic          host_local,
    input  wire logic          panel_local,
    input  wire logic          host_offset,
    input  wire logic          panel_offset,
    input  wire logic          host_bumpless,
    input  wire logic          panel_bumpless,
    input  wire logic          host_second,
    input  wire logic          panel_second,
    input  wire logic          contact_input_a,
    input  wire logic          contact_input_b,
    input  wire logic          contact_input_c,
    input  wire logic          contact_input_d,
    input  wire logic [2:0]    remote_select_source,
    input  wire logic [2:0]    offset_enable_source,
    input  wire logic [2:0]    bumpless_source,
    input  wire logic [2:0]    second_select_source,
    input  wire logic [1:0]    remote_input_select,
    input  wire logic [1:0]    offset_value_source,
    input  wire logic          remote_offset_select,
    input  wire logic          offset_multiply,
    input  wire logic          tracking_type_select,
    input  wire logic          profile_mode,
    input  wire logic [1:0]    limit_mode,
    input  wire logic [W-1:0]  default_analog_input,
    input  wire logic [W-1:0]  isolated_analog_input,
    input  wire logic [W-1:0]  feedback_analog_input,
    input  wire logic [W-1:0]  limit_analog_input,
    input  wire logic [W-1:0]  first_preprocessing,
    input  wire logic [W-1:0]  second_preprocessing,
    input  wire logic [W-1:0]  local_target_in,
    input  wire logic          local_target_load,
    input  wire logic [W-1:0]  profile_target,
    input  wire logic [W-1:0]  second_target,
    input  wire logic [W-1:0]  local_offset,
    input  wire logic [W-1:0]  process_value,
    input  wire logic [W-1:0]  rise_gradient,
    input  wire logic [W-1:0]  fall_gradient,
    input  wire logic [W-1:0]  second_target_gradient,
    output logic [W-1:0]       active_target,
    output logic [W-1:0]       local_target,
    output logic               remote_active,
    output logic               offset_active,
    output logic               second_active,
    output logic               bumpless_armed,
    output logic               cycle_tick
);
    typedef struct packed {
        ssr_state_t   state;
        logic [15:0]  div;
        logic         tick;
        logic         rem_req;
        logic         off_req;
        logic         bump_req;
        logic         sec_req;
        logic         remote;
        logic         offset;
        logic         second;
        logic         bumpless;
        logic         started;
        logic [W-1:0] goal;
        logic [W-1:0] act;
        logic [W-1:0] local_w;
        logic [W-1:0] out_w;
    } ssr_reg_t;

    ssr_reg_t r;
    ssr_reg_t next_r;

    ssr_req_if rem_if ();
    ssr_req_if off_if ();
    ssr_req_if bmp_if ();
    ssr_req_if sec_if ();

    // remote request: contact 1 and host/panel not asking for local
    // host and panel only ever ask for local, so only the contact can ask for remote
    assign rem_if.host = 1'b0;
    assign rem_if.panel = 1'b0;
    assign rem_if.contact_input_a = contact_input_a;
    assign rem_if.contact_input_b = contact_input_b;
    assign rem_if.contact_input_c = contact_input_c;
    assign rem_if.contact_input_d = contact_input_d;
    assign rem_if.src_sel = remote_select_source;
    assign off_if.host = host_offset;
    assign off_if.panel = panel_offset;
    assign off_if.contact_input_a = contact_input_a;
    assign off_if.contact_input_b = contact_input_b;
    assign off_if.contact_input_c = contact_input_c;
    assign off_if.contact_input_d = contact_input_d;
    assign off_if.src_sel = offset_enable_source;
    assign bmp_if.host = host_bumpless;
    assign bmp_if.panel = panel_bumpless;
    assign bmp_if.contact_input_a = contact_input_a;
    assign bmp_if.contact_input_b = contact_input_b;
    assign bmp_if.contact_input_c = contact_input_c;
    assign bmp_if.contact_input_d = contact_input_d;
    assign bmp_if.src_sel = bumpless_source;
    assign sec_if.host = host_second;
    assign sec_if.panel = panel_second;
    assign sec_if.contact_input_a = contact_input_a;
    assign sec_if.contact_input_b = contact_input_b;
    assign sec_if.contact_input_c = contact_input_c;
    assign sec_if.contact_input_d = contact_input_d;
    assign sec_if.src_sel = second_select_source;

    ssr_prio u_rem (.req(rem_if.arbiter));
    ssr_prio u_off (.req(off_if.arbiter));
    ssr_prio u_bmp (.req(bmp_if.arbiter));
    ssr_prio u_sec (.req(sec_if.arbiter));

    function automatic logic [W-1:0] pick_ain(input logic [1:0] s);
        logic [W-1:0] v;
        v = default_analog_input;
        if (s == AIN_ISOLATED) begin
            v = isolated_analog_input;
        end else if (s == AIN_FEEDBACK) begin
            v = feedback_analog_input;
        end
        return v;
    endfunction

    // two pre-processing stages: gain (8.8 fixed point) then additive shift
    function automatic logic [W-1:0] precond(input logic [W-1:0] x);
        logic [2*W-1:0] p;
        p = x * first_preprocessing;
        return p[W+7:8] + second_preprocessing;
    endfunction

    // one ramp step toward goal, never past it
    function automatic logic [W-1:0] step(input logic [W-1:0] a, input logic [W-1:0] g,
                                          input logic [W-1:0] up, input logic [W-1:0] dn);
        logic [W-1:0] v;
        v = g;
        if (g > a) begin
            if (up != GRAD_OFF && (g - a) > up) begin
                v = a + up;
            end
        end else if (a > g) begin
            if (dn != GRAD_OFF && (a - g) > dn) begin
                v = a - dn;
            end
        end
        return v;
    endfunction

    logic [W-1:0] remote_w;
    logic [W-1:0] offs;
    logic [W-1:0] base;
    logic [W-1:0] comb;
    logic [W-1:0] lim;
    logic [2*W-1:0] prod;
    logic          switched;
    logic [W-1:0]  up_g;
    logic [W-1:0]  dn_g;

    assign remote_w = precond(pick_ain(remote_input_select));

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        offs = remote_offset_select ? precond(pick_ain(offset_value_source)) : local_offset;
        base = r.second ? second_target :
            (r.remote ? (profile_mode ? profile_target : remote_w) : r.local_w);
        prod = base * offs;
        comb = base;
        if (r.offset && !r.second) begin
            comb = offset_multiply ? prod[W+7:8] : base + offs;
        end
        lim = comb;
        if (limit_mode == LIM_MIN && comb < limit_analog_input) begin
            lim = limit_analog_input;
        end else if (limit_mode == LIM_MAX && comb > limit_analog_input) begin
            lim = limit_analog_input;
        end
        switched = (r.second != r.sec_req) ||
                   (!r.sec_req && r.remote != r.rem_req) || !r.started;
        up_g = (r.second || r.sec_req) ? second_target_gradient : rise_gradient;
        dn_g = (r.second || r.sec_req) ? second_target_gradient : fall_gradient;
        if (local_target_load) begin
            next_r.local_w = local_target_in;
        end
        if (r.div == CYCLE_CLKS - 16'h0001) begin
            next_r.div = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + 16'h0001;
        end
        case (r.state)
            SSR_IDLE: begin
                if (r.tick) begin
                    // sample all sources once per control cycle
                    next_r.rem_req = rem_if.wins & ~(host_local | panel_local) &
                                     ~sec_if.wins;
                    next_r.off_req = off_if.wins;
                    next_r.bump_req = bmp_if.wins;
                    next_r.sec_req = sec_if.wins;
                    next_r.state = SSR_SELECT;
                end
            end
            SSR_SELECT: begin
                if (switched) begin
                    if (r.bumpless && !tracking_type_select && r.remote && !r.rem_req &&
                        !r.sec_req && r.started) begin
                        next_r.local_w = r.out_w;
                    end else begin
                        next_r.act = process_value;
                    end
                end
                next_r.started = 1'b1;
                next_r.second = r.sec_req;
                next_r.remote = r.rem_req;
                next_r.offset = r.off_req;
                next_r.bumpless = r.bump_req;
                next_r.state = SSR_COMB;
            end
            SSR_COMB: begin
                next_r.goal = lim;
                next_r.state = SSR_RAMP;
            end
            SSR_RAMP: begin
                next_r.act = step(r.act, r.goal, up_g, dn_g);
                next_r.out_w = step(r.act, r.goal, up_g, dn_g);
                next_r.state = SSR_IDLE;
            end
            default: begin
                next_r.state = SSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{state: SSR_IDLE, div: 16'h0000, tick: 1'b0, rem_req: 1'b0,
                   off_req: 1'b0, bump_req: 1'b0, sec_req: 1'b0, remote: 1'b0,
                   offset: 1'b0, second: 1'b0, bumpless: 1'b0, started: 1'b0,
                   goal: TARGET_RESET, act: TARGET_RESET, local_w: TARGET_RESET,
                   out_w: TARGET_RESET};
        end else begin
            r <= next_r;
        end
    end

    assign active_target = r.out_w;
    assign local_target = r.local_w;
    assign remote_active = r.remote;
    assign offset_active = r.offset;
    assign second_active = r.second;
    assign bumpless_armed = r.bumpless;
    assign cycle_tick = r.tick;
endmodule

// file: tb/ssr_top_asserts.sv
`timescale 1ns/10ps
module ssr_top_asserts
    import ssr_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst_b,
    input wire logic         host_local,
    input wire logic         panel_local,
    input wire logic         host_offset,
    input wire logic         panel_offset,
    input wire logic         host_second,
    input wire logic         panel_second,
    input wire logic         contact_input_a,
    input wire logic         contact_input_b,
    input wire logic         contact_input_c,
    input wire logic         contact_input_d,
    input wire logic [2:0]   remote_select_source,
    input wire logic [2:0]   offset_enable_source,
    input wire logic [2:0]   second_select_source,
    input wire logic [1:0]   limit_mode,
    input wire logic [W-1:0] limit_analog_input,
    input wire logic [W-1:0] rise_gradient,
    input wire logic [W-1:0] fall_gradient,
    input wire logic [W-1:0] active_target,
    input wire logic         remote_active,
    input wire logic         offset_active,
    input wire logic         second_active,
    input wire logic         bumpless_armed,
    input wire logic         cycle_tick
);
    logic sec;
    logic loc;
    logic off;

    function automatic logic pick(input logic [2:0] c);
        logic [3:0] k;
        k = {contact_input_d, contact_input_c, contact_input_b, contact_input_a};
        return (c >= 3'h2 && c <= 3'h5) ? k[c - 3'h2] : 1'b0;
    endfunction

    // a selected contact at 0 asks for the local target
    assign loc = host_local | panel_local | !pick(remote_select_source);
    assign sec = host_second | panel_second | pick(second_select_source);
    assign off = host_offset | panel_offset | pick(offset_enable_source);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_local_wins: assert property ($past(cycle_tick, 5) && $past(loc, 4) |-> !remote_active)
        else $error("remote target active under a local request");
    a_remote_sel: assert property ($past(cycle_tick, 5) && !$past(loc | sec, 4) |-> remote_active)
        else $error("remote target not taken");
    a_offset_sel: assert property ($past(cycle_tick, 5) |-> offset_active == $past(off, 4))
        else $error("offset state wrong");
    a_second_sel: assert property ($past(cycle_tick, 5) |-> second_active == $past(sec, 4))
        else $error("second target state wrong");
    a_status_hold: assert property (
        $changed({remote_active, offset_active, second_active, bumpless_armed})
        |-> $past(cycle_tick, 2) || $past(cycle_tick, 3))
        else $error("status changed outside the control cycle");
    a_target_hold: assert property (
        $changed(active_target) |-> $past(cycle_tick, 4) || $past(cycle_tick, 5))
        else $error("target moved outside the control cycle");
    a_limit_min: assert property (
        $past(cycle_tick, 8) && limit_mode == LIM_MIN && !second_active
        && rise_gradient == GRAD_OFF && fall_gradient == GRAD_OFF
        |-> active_target >= limit_analog_input)
        else $error("target below limit input");
    a_bump_stand: assert property ($past(cycle_tick, 5) |-> $stable(bumpless_armed))
        else $error("bumpless state unsettled");

    c_remote: cover property ($rose(remote_active));
    c_second: cover property ($rose(second_active));
    c_offset: cover property ($rose(offset_active));
endmodule

bind ssr_top ssr_top_asserts i_chk (.*);

// file: tb/ssr_panel.sv
`timescale 1ns/10ps
module ssr_panel (
    input  wire logic        clock,
    input  wire logic [11:0] want,
    output logic      [11:0] lines = 12'h000
);
    // contacts are levels, moved only off the sampling edge
    always @(negedge clock) begin
        lines <= want;
    end
endmodule

// file: tb/ssr_top_test.sv
`timescale 1ns/10ps
module ssr_top_test
    import ssr_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] remote_select_source, offset_enable_source, bumpless_source, second_select_source;
    logic [1:0] remote_input_select, offset_value_source, limit_mode;
    logic remote_offset_select, offset_multiply, tracking_type_select, profile_mode;
    logic local_target_load;
    logic [W-1:0] default_analog_input, isolated_analog_input, feedback_analog_input;
    logic [W-1:0] limit_analog_input, first_preprocessing, second_preprocessing, local_target_in;
    logic [W-1:0] profile_target, second_target, local_offset, process_value;
    logic [W-1:0] rise_gradient, fall_gradient, second_target_gradient;
    logic [W-1:0] active_target, local_target, st, ld;
    logic remote_active, offset_active, second_active, bumpless_armed, cycle_tick;
    logic es, el, er, eo, eb, pr, pb, cp;
    logic [11:0] want = 12'h000;
    logic [11:0] pl;
    logic [15:0] seed = 16'h0041;
    int n_mismatch = 0;
    int total_checks = 0;

    ssr_panel i_panel (.clock(clock), .want(want), .lines(pl));
    ssr_top i_dut (.*, .host_local(pl[0]), .panel_local(pl[1]), .host_offset(pl[2]),
        .panel_offset(pl[3]), .host_bumpless(pl[4]), .panel_bumpless(pl[5]),
        .host_second(pl[6]), .panel_second(pl[7]), .contact_input_a(pl[8]),
        .contact_input_b(pl[9]), .contact_input_c(pl[10]), .contact_input_d(pl[11]));

    always #5 clock = ~clock;

    function automatic logic [15:0] xs(input logic [15:0] s);
        s ^= s << 7;
        s ^= s >> 9;
        s ^= s << 8;
        return s;
    endfunction

    function automatic logic pick(input logic [2:0] c, input logic [3:0] k);
        return (c >= 3'h2 && c <= 3'h5) ? k[c - 3'h2] : 1'b0;
    endfunction

    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task results;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #900000;
        n_mismatch++;
        results();
    end

    initial begin
        {remote_select_source, offset_enable_source, bumpless_source, second_select_source,
         remote_input_select, offset_value_source, limit_mode, remote_offset_select,
         offset_multiply, tracking_type_select, profile_mode, local_target_load,
         default_analog_input, isolated_analog_input, feedback_analog_input,
         limit_analog_input, first_preprocessing, second_preprocessing, local_target_in,
         profile_target, second_target, local_offset, process_value, rise_gradient,
         fall_gradient, second_target_gradient} = '0;
        pr = 1'b0;
        pb = 1'b0;
        repeat (10) @(posedge clock);
        @(negedge clock) rst_b = 1'b1;
        @(posedge cycle_tick);
        // keep inputs clear of the sampling window after the tick
        repeat (20) @(negedge clock);
        for (int k = 0; k < 7; k++) begin
            seed = xs(seed);
            want = {seed[3:0], seed[5:4] & seed[9:8], seed[15:12], seed[11:10] & seed[7:6]};
            remote_select_source = 3'(2 + k % 4);
            offset_enable_source = 3'(k % 6);
            bumpless_source = 3'((k + 1) % 6);
            second_select_source = 3'((k + 2) % 6);
            limit_mode = 2'(k % 3);
            {remote_offset_select, offset_multiply, tracking_type_select} = 3'(k);
            remote_input_select = 2'(k % 3);
            offset_value_source = 2'((k + 1) % 3);
            default_analog_input = xs(seed);
            second_target = xs(default_analog_input);
            limit_analog_input = seed ^ 16'h0f0f;
            ld = seed ^ 16'h5a5a;
            local_target_in = ld;
            local_target_load = 1'b1;
            @(negedge clock) local_target_load = 1'b0;
            es = pick(second_select_source, want[11:8]) | want[6] | want[7];
            el = want[0] | want[1] | !pick(remote_select_source, want[11:8]);
            er = !es & !el;
            eo = want[2] | want[3] | pick(offset_enable_source, want[11:8]);
            eb = want[4] | want[5] | pick(bumpless_source, want[11:8]);
            // copy uses the armed state and source of the cycle before
            cp = pr & pb & el & !es & !tracking_type_select;
            @(posedge cycle_tick);
            repeat (9) @(negedge clock);
            st = {12'h000, remote_active, offset_active, second_active, bumpless_armed};
            check(st, {12'h000, er, eo, es, eb});
            if (es && limit_mode == LIM_OFF) begin
                check(active_target, second_target);
            end
            if (!cp) begin
                check(local_target, ld);
            end
            if (el && !es && !eo && !cp && limit_mode == LIM_OFF) begin
                check(active_target, ld);
            end
            pr = er;
            pb = eb;
        end
        results();
    end
endmodule
